// File: bench/tb_top.sv
// self-checking bench for the always-on sleep countdown timer
`timescale 1ns/1ps
`include "aost_cfg.svh"
module tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sleep_clk;
    logic        timer_tick;
    logic        irq;
    logic        wake_cpu;
    logic        wake_radio;
    logic [31:0] rd;
    logic        er;
    logic [31:0] ivs [3];
    int          fails = 0;
    int          check_count = 0;
    int          ticks = 0;

    aost_sleep_timer uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_clk(sleep_clk),
        .timer_tick(timer_tick), .irq(irq), .wake_cpu(wake_cpu),
        .wake_radio(wake_radio)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (timer_tick === 1'b1) ticks <= ticks + 1;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    task automatic chk_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_flag(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_flag

    // request held until pready is sampled high; ends mid-cycle settled
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdv(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rdv

    // one sleep clock period, slow enough for the two-flop synchroniser
    task automatic step();
        @(posedge pclk);
        sleep_clk <= 1'b1;
        repeat (6) @(posedge pclk);
        sleep_clk <= 1'b0;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
    endtask : step

    function automatic int exp_steps(input logic [31:0] n);
        return (n == 32'h0) ? 1 : int'(n);
    endfunction : exp_steps

    task automatic run(input logic [31:0] n, input logic per,
                       input logic both);
        int e;
        int t0;
        e = exp_steps(n);
        wr(`AOST_INTVL_OFF, n);
        wr(`AOST_CTRL_OFF, per ? {30'h0, both, 1'b1} : 32'h0000_0002);
        rdv(`AOST_CTRL_OFF);
        chk_flag("active", 1'b1, rd[`AOST_ACTIVE_BIT]);
        step();
        rdv(`AOST_COUNT_OFF);
        chk_word("loaded count", n, rd);
        rdv(`AOST_CTRL_OFF);
        if (per) chk_word("rdly", 32'h2, {30'h0, rd[9:8]});
        else chk_word("sdly", 32'h2, {29'h0, rd[14:12]});
        t0 = ticks;
        for (int k = 1; k < e; k++) begin
            step();
            rdv(`AOST_COUNT_OFF);
            chk_word("count", n - 32'(k), rd);
        end
        chk_word("early ticks", 32'(t0), 32'(ticks));
        step();
        chk_word("ticks", 32'(t0 + 1), 32'(ticks));
        rdv(`AOST_COUNT_OFF);
        chk_word("count at zero", per ? n : 32'h0, rd);
        chk_flag("irq", 1'b1, irq);
        if (per) begin
            wr(`AOST_CTRL_OFF, 32'h0000_0000);
            chk_flag("irq zero write", 1'b1, irq);
            repeat (e - 1) step();
            rdv(`AOST_COUNT_OFF);
            chk_word("count after stop req", 32'h1, rd);
        end
        repeat (per ? 3 : 2) step();
        rdv(`AOST_COUNT_OFF);
        chk_word("stopped count", 32'h0, rd);
        chk_word("total ticks", 32'(t0 + (per ? 2 : 1)), 32'(ticks));
        rdv(`AOST_CTRL_OFF);
        chk_flag("not active", 1'b1, rd[`AOST_IDLE_BIT]);
        $display("test run interval %0d periodic %0b done", n, per);
    endtask : run

    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0000_0000;
        sleep_clk = 1'b0;
        void'($urandom(1));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdv(`AOST_CTRL_OFF);
        chk_word("ctrl reset", 32'h8000_0000, rd);
        chk_flag("mapped err", 1'b0, er);
        rdv(`AOST_WAKE_OFF);
        chk_word("wake reset", 32'h0, rd);
        rdv(`AOST_MASK_OFF);
        chk_word("mask reset", 32'h1, rd);
        chk_flag("wake cpu reset", 1'b0, wake_cpu);
        chk_flag("wake radio reset", 1'b0, wake_radio);
        repeat (2) step();
        rdv(`AOST_COUNT_OFF);
        chk_word("idle count", 32'h0, rd);
        chk_word("idle ticks", 32'h0, 32'(ticks));
        wr(12'h020, $urandom);
        chk_flag("unmapped write err", 1'b1, er);
        rdv(12'h020);
        chk_flag("unmapped read err", 1'b1, er);
        chk_word("unmapped read", 32'h0, rd);
        $display("test reset done");
        ivs[0] = 32'h0;
        ivs[1] = 32'h1;
        ivs[2] = 32'h2 + ($urandom % 5);
        for (int i = 0; i < 3; i++) begin
            run(ivs[i], 1'b0, 1'b0);
            wr(`AOST_CTRL_OFF, 32'h0000_0000);
            chk_flag("irq zero write", 1'b1, irq);
            wr(`AOST_CTRL_OFF, 32'h0000_0004);
            chk_flag("irq cleared", 1'b0, irq);
            rdv(`AOST_CTRL_OFF);
            chk_flag("clear bit reads", 1'b0, rd[`AOST_CLEAR_BIT]);
        end
        run(32'h2 + ($urandom % 5), 1'b1, 1'b0);
        run(32'h2, 1'b1, 1'b1);
        wr(`AOST_CTRL_OFF, 32'h0000_0004);
        chk_flag("irq cleared", 1'b0, irq);
        run(32'h3, 1'b0, 1'b0);
        wr(`AOST_WAKE_OFF, 32'h0000_0003);
        chk_flag("wake cpu", 1'b1, wake_cpu);
        chk_flag("wake radio", 1'b1, wake_radio);
        wr(`AOST_WAKE_OFF, 32'h0000_0001);
        chk_flag("wake radio off", 1'b0, wake_radio);
        wr(`AOST_MASK_OFF, 32'h0000_0000);
        chk_flag("irq masked", 1'b0, irq);
        wr(`AOST_MASK_OFF, 32'h0000_0001);
        chk_flag("irq unmasked", 1'b1, irq);
        wr(`AOST_STAT_OFF, 32'h0000_0001);
        chk_flag("irq status clear", 1'b0, irq);
        chk_flag("wake cpu clear", 1'b0, wake_cpu);
        rdv(`AOST_STAT_OFF);
        chk_word("status load only", 32'h2, rd);
        wr(`AOST_MASK_OFF, 32'h0000_0002);
        chk_flag("irq load event", 1'b1, irq);
        wr(`AOST_STAT_OFF, 32'h0000_0002);
        chk_flag("irq load clear", 1'b0, irq);
        $display("test wake and mask done");
        wr(`AOST_INTVL_OFF, 32'h0000_0005);
        wr(`AOST_CTRL_OFF, 32'h0000_0002);
        repeat (2) step();
        chk_flag("irq before reset", 1'b1, irq);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdv(`AOST_CTRL_OFF);
        chk_word("ctrl after reset", 32'h8000_0000, rd);
        rdv(`AOST_COUNT_OFF);
        chk_word("count after reset", 32'h0, rd);
        rdv(`AOST_MASK_OFF);
        chk_word("mask after reset", 32'h1, rd);
        chk_flag("irq after reset", 1'b0, irq);
        step();
        rdv(`AOST_COUNT_OFF);
        chk_word("idle after reset", 32'h0, rd);
        $display("test mid-run reset done");
        summarize();
    end

    // whole sequence needs under about a thousand cycles
    initial begin
        repeat (50000) @(posedge pclk);
        fails++;
        $display("MISMATCH watchdog expected done seen hang");
        summarize();
    end
endmodule : tb_top

// File: hdl/aost_cfg.svh
// register map, field positions and reset values of the sleep timer
`ifndef AOST_CFG_SVH
`define AOST_CFG_SVH
`define AOST_CTRL_OFF    12'h000
`define AOST_INTVL_OFF   12'h004
`define AOST_COUNT_OFF   12'h00C
`define AOST_WAKE_OFF    12'h010
`define AOST_STAT_OFF    12'h014
`define AOST_MASK_OFF    12'h018
`define AOST_RELOAD_BIT  0
`define AOST_SINGLE_BIT  1
`define AOST_CLEAR_BIT   2
`define AOST_RDLY_LSB    8
`define AOST_SDLY_LSB    12
`define AOST_ACTIVE_BIT  30
`define AOST_IDLE_BIT    31
`define AOST_RDLY_DONE   2'h2
`define AOST_SDLY_DONE   3'h2
`define AOST_EV_TICK     0
`define AOST_EV_LOAD     1
`define AOST_MASK_RST    2'h1
`define AOST_WAKE_RST    2'h0
`define AOST_STAT_RST    2'h0
`endif

// File: hdl/aost_cnt_if.sv
// control and status between register file and countdown core
`timescale 1ns/1ps
interface aost_cnt_if;
    logic        step;
    logic        start;
    logic        periodic_en;
    logic [31:0] interval;
    logic [31:0] count;
    logic        active;
    logic        loaded;
    logic        periodic;
    logic        tick;
    modport ctl (output step, start, periodic_en, interval,
                 input count, active, loaded, periodic, tick);
    modport cnt (input step, start, periodic_en, interval,
                 output count, active, loaded, periodic, tick);
endinterface : aost_cnt_if

// File: hdl/aost_counter.sv
// countdown core stepped by synchronised sleep clock edges
`timescale 1ns/1ps
module aost_counter (
    input wire logic pclk,
    input wire logic presetn,
    aost_cnt_if.cnt  cif
);
    aost_pkg::aost_state_t state_r;
    logic [31:0]           count_r;
    logic                  tick_r;
    logic                  periodic_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= aost_pkg::AOST_IDLE;
            count_r    <= 32'h0000_0000;
            tick_r     <= 1'b0;
            periodic_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            case (state_r)
                aost_pkg::AOST_IDLE: begin
                    if (cif.start) begin
                        periodic_r <= cif.periodic_en;
                        state_r    <= aost_pkg::AOST_LOAD;
                    end
                end
                aost_pkg::AOST_LOAD: begin
                    if (cif.step) begin
                        count_r <= cif.interval;
                        state_r <= aost_pkg::AOST_RUN;
                    end
                end
                aost_pkg::AOST_RUN: begin
                    if (cif.step) begin
                        if (count_r > 32'h0000_0001) begin
                            count_r <= count_r - 32'h0000_0001;
                        end else begin
                            tick_r <= 1'b1;
                            // while running, the run bit is looked at only here, at zero
                            if (periodic_r && cif.periodic_en) begin
                                count_r <= cif.interval;
                            end else begin
                                count_r <= 32'h0000_0000;
                                state_r <= aost_pkg::AOST_IDLE;
                            end
                        end
                    end
                end
                default: state_r <= aost_pkg::AOST_IDLE;
            endcase
        end
    end

    assign cif.count    = count_r;
    assign cif.tick     = tick_r;
    assign cif.periodic = periodic_r;
    assign cif.active   = (state_r != aost_pkg::AOST_IDLE);
    assign cif.loaded   = (state_r == aost_pkg::AOST_RUN);

    sequence s_run_step;
        state_r == aost_pkg::AOST_RUN && cif.step;
    endsequence
    sequence s_last_step;
        s_run_step ##0 count_r <= 32'h0000_0001;
    endsequence

    a_count_steps_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_run_step ##0 count_r > 32'h0000_0001
        |=> count_r == $past(count_r) - 32'h0000_0001)
        else $error("count did not step down by one");
    a_count_sleep_only: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cif.step |=> $stable(count_r))
        else $error("count moved without a sleep clock step");
    a_enable_loads: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_r == aost_pkg::AOST_LOAD && cif.step
        |=> count_r == $past(cif.interval))
        else $error("interval not copied at start");
    a_oneshot_stops: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_last_step ##0 !periodic_r
        |=> tick_r && state_r == aost_pkg::AOST_IDLE)
        else $error("one-shot did not stop at zero");
    a_periodic_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_last_step ##0 periodic_r && cif.periodic_en
        |=> tick_r && count_r == $past(cif.interval))
        else $error("periodic mode did not reload");
endmodule : aost_counter

// File: hdl/aost_pkg.sv
// types shared by the sleep timer modules
package aost_pkg;
    typedef enum logic [1:0] {
        AOST_IDLE,
        AOST_LOAD,
        AOST_RUN
    } aost_state_t;
endpackage : aost_pkg

// File: hdl/aost_sleep_timer.sv
// always-on sleep countdown timer with APB registers and wake outputs
// Behaviour
// - 32-bit count steps only on sleep clock
// - timer idle after reset until enabled
// - count drops by one per sleep tick
// - zero gives tick and interrupt request
// - one-shot stops at zero, no reload
// - periodic reloads interval at each zero
// - enabling copies interval into live count
// - writing one to clear bit drops request
// - timer can wake cpu and radio
// - cleared run bit stops only at zero
// - wake use disabled until software enables
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "aost_cfg.svh"
module aost_sleep_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_clk,
    output logic             timer_tick,
    output logic             irq,
    output logic             wake_cpu,
    output logic             wake_radio
);
    aost_cnt_if cif ();

    logic        sclk_meta_r;
    logic        sclk_sync_r;
    logic        sclk_last_r;
    logic        reload_en_r;
    logic        single_en_r;
    logic        start_r;
    logic [31:0] interval_r;
    logic [1:0]  wake_sel_r;
    logic [1:0]  stat_r;
    logic [1:0]  mask_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic [31:0] ctrl_rd;
    logic        mapped;
    logic        wr_en;
    logic        rd_setup;
    logic        clr_tick;
    logic [1:0]  stat_clr;
    logic [1:0]  stat_set;

    // sleep clock is asynchronous: two flops, then edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_meta_r <= 1'b0;
            sclk_sync_r <= 1'b0;
            sclk_last_r <= 1'b0;
        end else begin
            sclk_meta_r <= sleep_clk;
            sclk_sync_r <= sclk_meta_r;
            sclk_last_r <= sclk_sync_r;
        end
    end

    assign cif.step = sclk_sync_r && !sclk_last_r;

    always_comb begin
        case (paddr)
            `AOST_CTRL_OFF,
            `AOST_INTVL_OFF,
            `AOST_COUNT_OFF,
            `AOST_WAKE_OFF,
            `AOST_STAT_OFF,
            `AOST_MASK_OFF: mapped = 1'b1;
            default:        mapped = 1'b0;
        endcase
    end

    assign wr_en    = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    // zero wait states; read data is captured in the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;

    // run bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_en_r <= 1'b0;
            single_en_r <= 1'b0;
        end else if (wr_en && paddr == `AOST_CTRL_OFF) begin
            reload_en_r <= pwdata[`AOST_RELOAD_BIT];
            single_en_r <= pwdata[`AOST_SINGLE_BIT];
        end
    end

    // a start is a write that sets a run bit; one-shot bit left set
    // does not retrigger the timer after it stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 1'b0;
        end else begin
            start_r <= wr_en && paddr == `AOST_CTRL_OFF
                       && (pwdata[`AOST_RELOAD_BIT]
                           || pwdata[`AOST_SINGLE_BIT]);
        end
    end

    assign cif.start       = start_r;
    assign cif.periodic_en = reload_en_r;
    assign cif.interval    = interval_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_r <= 32'h0000_0000;
        end else if (wr_en && paddr == `AOST_INTVL_OFF) begin
            interval_r <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_sel_r <= `AOST_WAKE_RST;
        end else if (wr_en && paddr == `AOST_WAKE_OFF) begin
            wake_sel_r <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `AOST_MASK_RST;
        end else if (wr_en && paddr == `AOST_MASK_OFF) begin
            mask_r <= pwdata[1:0];
        end
    end

    // clear bit is a strobe, never stored; a zero there does nothing
    assign clr_tick = wr_en && paddr == `AOST_CTRL_OFF
                      && pwdata[`AOST_CLEAR_BIT];

    always_comb begin
        stat_clr = 2'h0;
        if (wr_en && paddr == `AOST_STAT_OFF) begin
            stat_clr = pwdata[1:0];
        end
        stat_clr[`AOST_EV_TICK] = stat_clr[`AOST_EV_TICK] || clr_tick;
    end

    assign stat_set[`AOST_EV_TICK] = cif.tick;
    assign stat_set[`AOST_EV_LOAD] = cif.step && cif.active
                                     && !cif.loaded;

    // set wins over a clear in the same cycle so no tick is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= `AOST_STAT_RST;
        end else begin
            stat_r <= stat_set | (stat_r & ~stat_clr);
        end
    end

    assign irq        = |(stat_r & mask_r);
    assign timer_tick = cif.tick;
    assign wake_cpu   = stat_r[`AOST_EV_TICK] && wake_sel_r[0];
    assign wake_radio = stat_r[`AOST_EV_TICK] && wake_sel_r[1];

    always_comb begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[`AOST_RELOAD_BIT] = reload_en_r;
        ctrl_rd[`AOST_SINGLE_BIT] = single_en_r;
        if (cif.loaded && cif.periodic) begin
            ctrl_rd[`AOST_RDLY_LSB +: 2] = `AOST_RDLY_DONE;
        end
        if (cif.loaded && !cif.periodic) begin
            ctrl_rd[`AOST_SDLY_LSB +: 3] = `AOST_SDLY_DONE;
        end
        ctrl_rd[`AOST_ACTIVE_BIT] = cif.active;
        ctrl_rd[`AOST_IDLE_BIT]   = !cif.active;
    end

    always_comb begin
        case (paddr)
            `AOST_CTRL_OFF:  rd_nxt = ctrl_rd;
            `AOST_INTVL_OFF: rd_nxt = interval_r;
            `AOST_COUNT_OFF: rd_nxt = cif.count;
            `AOST_WAKE_OFF:  rd_nxt = {30'h0, wake_sel_r};
            `AOST_STAT_OFF:  rd_nxt = {30'h0, stat_r};
            `AOST_MASK_OFF:  rd_nxt = {30'h0, mask_r};
            default:         rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_r <= rd_nxt;
        end
    end

    assign prdata = prdata_r;

    aost_counter u_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif.cnt)
    );

    a_tick_sets_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        cif.tick |=> stat_r[`AOST_EV_TICK])
        else $error("tick did not raise the flag");
    a_flag_held: assert property (
        @(posedge pclk) disable iff (!presetn)
        stat_r[`AOST_EV_TICK] && !stat_clr[`AOST_EV_TICK]
        |=> stat_r[`AOST_EV_TICK])
        else $error("tick flag dropped without a clear");
    a_clear_drops: assert property (
        @(posedge pclk) disable iff (!presetn)
        clr_tick && !cif.tick |=> !stat_r[`AOST_EV_TICK])
        else $error("clear bit did not drop the request");
    a_clear_zero_noop: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `AOST_CTRL_OFF && !pwdata[`AOST_CLEAR_BIT]
        && stat_r[`AOST_EV_TICK] && !clr_tick
        |=> stat_r[`AOST_EV_TICK])
        else $error("writing zero to clear bit had an effect");
    a_wake_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wake_cpu |-> wake_sel_r[0]) and (wake_radio |-> wake_sel_r[1]))
        else $error("wake raised while not selected");
    a_idle_no_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cif.active && !start_r |=> !cif.active)
        else $error("timer became active without an enable");

    // status, interrupt and wake paths
    a_load_flag_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        stat_set[`AOST_EV_LOAD] |=> stat_r[`AOST_EV_LOAD])
        else $error("load did not raise its flag");
    a_wake_needs_tick: assert property (
        @(posedge pclk) disable iff (!presetn)
        wake_cpu || wake_radio |-> stat_r[`AOST_EV_TICK])
        else $error("wake raised without a tick");
    a_wake_both: assert property (
        @(posedge pclk) disable iff (!presetn)
        stat_r[`AOST_EV_TICK] && wake_sel_r == 2'h3
        |-> wake_cpu && wake_radio)
        else $error("selected wake output missing");
    a_wake_off_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        wake_sel_r == `AOST_WAKE_RST |-> !wake_cpu && !wake_radio)
        else $error("wake raised while wake use disabled");
    a_irq_on_tick: assert property (
        @(posedge pclk) disable iff (!presetn)
        cif.tick && mask_r[`AOST_EV_TICK] |=> irq)
        else $error("tick did not raise the interrupt");
    a_irq_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq && stat_clr == 2'h0 && !(wr_en && paddr == `AOST_MASK_OFF)
        |=> irq)
        else $error("interrupt dropped without a clear");
    a_tick_single: assert property (
        @(posedge pclk) disable iff (!presetn)
        timer_tick |=> !timer_tick)
        else $error("tick wider than one cycle");
    a_clear_not_stored: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ctrl_rd[`AOST_CLEAR_BIT])
        else $error("clear bit read back as set");

    // start, step and stop paths
    a_step_single: assert property (
        @(posedge pclk) disable iff (!presetn)
        cif.step |=> !cif.step)
        else $error("one sleep edge gave two steps");
    a_start_strobe: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `AOST_CTRL_OFF
        && (pwdata[`AOST_RELOAD_BIT] || pwdata[`AOST_SINGLE_BIT])
        |=> start_r)
        else $error("run bit write gave no start");
    a_start_activates: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_r && !cif.active |=> cif.active && !cif.loaded)
        else $error("start did not enter the load phase");
    a_stop_at_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        cif.loaded && cif.step && cif.count <= 32'h0000_0001
        && !cif.periodic_en |=> !cif.active)
        else $error("timer ran on after zero with run bit clear");
    a_idle_count_still: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cif.active |=> $stable(cif.count))
        else $error("count moved while the timer was idle");
endmodule : aost_sleep_timer
